// [cev_pkg.sv]
// constants, types and codes of the exception and interrupt vectoring unit
// assumes a 16-bit core whose pipeline reports each instruction end to this unit
package cev_pkg;
   localparam int unsigned VEC_W      = 8;
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned TBL_SHIFT  = 2;
   localparam logic [15:0] WORD_BYTES = 16'h0002;

   localparam logic [7:0] VEC_DIV    = 8'h00;
   localparam logic [7:0] VEC_STEP   = 8'h01;
   localparam logic [7:0] VEC_NMI    = 8'h02;
   localparam logic [7:0] VEC_BRK    = 8'h03;
   localparam logic [7:0] VEC_OVF    = 8'h04;
   localparam logic [7:0] VEC_RANGE  = 8'h05;
   localparam logic [7:0] VEC_UNDEF  = 8'h06;
   localparam logic [7:0] VEC_COPRO  = 8'h07;

   localparam logic [7:0] OPC_BRK      = 8'hcc;
   localparam logic [7:0] OPC_TRAP_N   = 8'hcd;
   localparam logic [7:0] OPC_OVF_TRAP = 8'hce;
   localparam logic [7:0] OPC_RANGE    = 8'h62;
   localparam logic [7:0] OPC_COPRO_LO = 8'hd8;
   localparam logic [7:0] OPC_COPRO_HI = 8'hdf;
   localparam logic [7:0] OPC_WAIT     = 8'h9b;

   localparam int unsigned SW_STEP_BIT = 8;
   localparam int unsigned SW_IE_BIT   = 9;
   localparam int unsigned SW_OVF_BIT  = 11;

   typedef enum logic [1:0] {
      CEV_OP_PUSH  = 2'h0,
      CEV_OP_ACK   = 2'h1,
      CEV_OP_TABLE = 2'h2
   } cev_bus_op_t;

   // gray codes along the entry path through CEV_ACK; the direct step from CEV_IDLE to CEV_PSW flips two bits
   typedef enum logic [2:0] {
      CEV_IDLE = 3'h0,
      CEV_ACK  = 3'h1,
      CEV_PSW  = 3'h3,
      CEV_PCS  = 3'h2,
      CEV_PIP  = 3'h6,
      CEV_RIP  = 3'h7,
      CEV_RCS  = 3'h5,
      CEV_JMP  = 3'h4
   } cev_state_t;
endpackage

// [cev_dec_if.sv]
// carries one finished instruction to the trap classifier and its verdict back
// assumes all signals are valid in the cycle the pipeline flags an instruction end
`timescale 1ns/1ps
`default_nettype none
interface cev_dec_if;
   logic [7:0]  opcode;
   logic [7:0]  imm8;
   logic        ovf;
   logic        div_ovf;
   logic        undef;
   logic [15:0] range_idx;
   logic [15:0] range_lo;
   logic [15:0] range_hi;
   logic        exc;
   logic [7:0]  vec;
   logic        at_start;
   logic        no_step;
   modport dec (input opcode, imm8, ovf, div_ovf, undef, range_idx, range_lo, range_hi,
                output exc, vec, at_start, no_step);
   modport use_side (output opcode, imm8, ovf, div_ovf, undef, range_idx, range_lo,
                     range_hi, input exc, vec, at_start, no_step);
endinterface
`default_nettype wire

// [cev_trap_decode.sv]
// classifies a finished instruction into an exception or software trap and its type
// assumes opcode is the first non-prefix byte and range operands are already fetched
`timescale 1ns/1ps
`default_nettype none
module cev_trap_decode (
   cev_dec_if.dec d
);
   import cev_pkg::*;

   function automatic logic is_no_step(input logic [7:0] op);
      case (op)
         8'h26, 8'h2e, 8'h36, 8'h3e, 8'hf0, 8'hf2, 8'hf3: is_no_step = 1'b1;
         8'h8e, 8'h07, 8'h17, 8'h1f:                      is_no_step = 1'b1;
         OPC_WAIT:                                        is_no_step = 1'b1;
         default:                                         is_no_step = 1'b0;
      endcase
   endfunction

   logic out_of_range;

   always_comb begin
      out_of_range = ($signed(d.range_idx) < $signed(d.range_lo)) ||
                     ($signed(d.range_idx) > $signed(d.range_hi));
      d.exc      = 1'b1;
      d.vec      = VEC_DIV;
      d.at_start = 1'b0;
      d.no_step  = is_no_step(d.opcode);
      // one-cycle priority: a faulting instruction cannot also be a trap instruction
      if (d.undef) begin
         d.vec = VEC_UNDEF;
      end else if (d.opcode >= OPC_COPRO_LO && d.opcode <= OPC_COPRO_HI) begin
         d.vec      = VEC_COPRO;
         d.at_start = 1'b1;
      end else if (d.div_ovf) begin
         d.vec = VEC_DIV;
      end else if (d.opcode == OPC_BRK) begin
         d.vec = VEC_BRK;
      end else if (d.opcode == OPC_TRAP_N) begin
         d.vec = d.imm8;
      end else if (d.opcode == OPC_OVF_TRAP && d.ovf) begin
         d.vec = VEC_OVF;
      end else if (d.opcode == OPC_RANGE && out_of_range) begin
         d.vec = VEC_RANGE;
      end else begin
         d.exc = 1'b0;
      end
   end
endmodule
`default_nettype wire

// [cev_vector_unit.sv]
// interrupt and exception entry sequencer of the core
// assumes the pipeline stalls while busy_out is high and its bus unit runs each request
`timescale 1ns/1ps
`default_nettype none
module cev_vector_unit #(
   parameter int unsigned TBL_ENTRIES = 256
) (
   // clock and reset
   input  wire logic                      clk_sys_in,
   input  wire logic                      nrst_in,
   // instruction end from the pipeline
   input  wire logic                      boundary_in,
   input  wire logic [7:0]                opcode_in,
   input  wire logic [7:0]                imm8_in,
   input  wire logic                      div_ovf_in,
   input  wire logic                      undef_in,
   input  wire logic [15:0]               range_idx_in,
   input  wire logic [15:0]               range_lo_in,
   input  wire logic [15:0]               range_hi_in,
   input  wire logic [15:0]               flags_in,
   input  wire logic [15:0]               code_seg_in,
   input  wire logic [15:0]               next_ptr_in,
   input  wire logic [15:0]               start_ptr_in,
   // hardware requests
   input  wire logic                      nmi_in,
   input  wire logic                      intr_req_in,
   input  wire logic                      intr_internal_in,
   input  wire logic [cev_pkg::VEC_W-1:0] intr_vec_in,
   output logic                           intr_taken_out,
   // bus unit requests
   output logic                           bus_req_out,
   output cev_pkg::cev_bus_op_t           bus_op_out,
   output logic [15:0]                    bus_addr_out,
   output logic [15:0]                    bus_wdata_out,
   input  wire logic                      bus_done_in,
   input  wire logic [15:0]               bus_rdata_in,
   // results to the pipeline
   output logic                           busy_out,
   output logic                           flags_wr_out,
   output logic [15:0]                    flags_out,
   output logic                           redirect_out,
   output logic [15:0]                    new_code_seg_out,
   output logic [15:0]                    new_ptr_out,
   output logic [cev_pkg::VEC_W-1:0]      vec_out
);
   import cev_pkg::*;

   if (TBL_ENTRIES < 32 || TBL_ENTRIES > 256) begin : g_chk
      $error("TBL_ENTRIES must lie between 32 and 256");
   end

   typedef struct packed {
      cev_state_t  st;
      cev_bus_op_t op;
      logic [7:0]  vec;
      logic [15:0] ret_ptr;
      logic [15:0] code_seg;
      logic [15:0] sw;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] flags;
      logic [15:0] new_ptr;
      logic [15:0] new_seg;
      logic        flags_wr;
      logic        redirect;
      logic        intr_taken;
      logic        nmi_s1;
      logic        nmi_s2;
      logic        nmi_d;
      logic        nmi_pend;
   } cev_core_t;

   cev_core_t r, n;
   cev_dec_if dif ();

   function automatic logic [15:0] tbl_addr(input logic [7:0] v);
      tbl_addr = {6'h00, v, 2'h0};
   endfunction

   assign dif.opcode    = opcode_in;
   assign dif.imm8      = imm8_in;
   assign dif.ovf       = flags_in[SW_OVF_BIT];
   assign dif.div_ovf   = div_ovf_in;
   assign dif.undef     = undef_in;
   assign dif.range_idx = range_idx_in;
   assign dif.range_lo  = range_lo_in;
   assign dif.range_hi  = range_hi_in;

   cev_trap_decode u_dec (
      .d (dif.dec)
   );

   logic nmi_edge;
   logic nmi_clr;
   logic go;
   logic take_nmi;
   logic take_intr;
   logic take_step;

   always_comb begin
      n            = r;
      n.flags_wr   = 1'b0;
      n.redirect   = 1'b0;
      n.intr_taken = 1'b0;
      n.nmi_s1     = nmi_in;
      n.nmi_s2     = r.nmi_s1;
      n.nmi_d      = r.nmi_s2;
      nmi_edge     = r.nmi_s2 & ~r.nmi_d;
      nmi_clr      = 1'b0;
      go           = 1'b0;
      // requests are looked at only at an instruction end; flags_in already carries
      // any enable just restored by the returning instruction
      take_nmi  = !dif.exc && r.nmi_pend;
      take_intr = !dif.exc && !r.nmi_pend && intr_req_in && flags_in[SW_IE_BIT];
      take_step = !dif.exc && !r.nmi_pend && !take_intr && flags_in[SW_STEP_BIT] &&
                  !dif.no_step;
      case (r.st)
         CEV_IDLE: begin
            if (boundary_in) begin
               go        = dif.exc | take_nmi | take_intr | take_step;
               n.ret_ptr = next_ptr_in;
               if (dif.exc) begin
                  n.vec = dif.vec;
                  if (dif.at_start) begin
                     n.ret_ptr = start_ptr_in;
                  end
               end else if (take_nmi) begin
                  n.vec   = VEC_NMI;
                  nmi_clr = 1'b1;
               end else if (take_intr) begin
                  n.vec        = intr_vec_in;
                  n.intr_taken = 1'b1;
               end else if (take_step) begin
                  // vec_out keeps the last entry's type when nothing is served
                  n.vec = VEC_STEP;
               end
            end
            if (go) begin
               n.sw       = flags_in;
               n.code_seg = code_seg_in;
               n.flags    = flags_in;
               n.flags[SW_IE_BIT]   = 1'b0;
               n.flags[SW_STEP_BIT] = 1'b0;
               n.flags_wr = 1'b1;
               n.wdata    = flags_in;
               n.addr     = '0;
               if (take_intr && !intr_internal_in) begin
                  n.st = CEV_ACK;
                  n.op = CEV_OP_ACK;
               end else begin
                  n.st = CEV_PSW;
                  n.op = CEV_OP_PUSH;
               end
            end
         end
         CEV_ACK: begin
            if (bus_done_in) begin
               n.vec = bus_rdata_in[VEC_W-1:0];
               n.st  = CEV_PSW;
               n.op  = CEV_OP_PUSH;
            end
         end
         CEV_PSW: begin
            if (bus_done_in) begin
               n.wdata = r.code_seg;
               n.st    = CEV_PCS;
            end
         end
         CEV_PCS: begin
            if (bus_done_in) begin
               n.wdata = r.ret_ptr;
               n.st    = CEV_PIP;
            end
         end
         CEV_PIP: begin
            if (bus_done_in) begin
               n.addr = tbl_addr(r.vec);
               n.op   = CEV_OP_TABLE;
               n.st   = CEV_RIP;
            end
         end
         CEV_RIP: begin
            if (bus_done_in) begin
               n.new_ptr = bus_rdata_in;
               n.addr    = r.addr + WORD_BYTES;
               n.st      = CEV_RCS;
            end
         end
         CEV_RCS: begin
            if (bus_done_in) begin
               n.new_seg  = bus_rdata_in;
               n.redirect = 1'b1;
               n.st       = CEV_JMP;
            end
         end
         CEV_JMP: begin
            n.st = CEV_IDLE;
         end
         default: begin
            n.st = CEV_IDLE;
         end
      endcase
      // a new edge in the clearing cycle stays pending
      n.nmi_pend = nmi_edge | (r.nmi_pend & ~nmi_clr);
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign busy_out         = (r.st != CEV_IDLE);
   assign bus_req_out      = (r.st != CEV_IDLE) && (r.st != CEV_JMP);
   assign bus_op_out       = r.op;
   assign bus_addr_out     = r.addr;
   assign bus_wdata_out    = r.wdata;
   assign flags_wr_out     = r.flags_wr;
   assign flags_out        = r.flags;
   assign redirect_out     = r.redirect;
   assign new_code_seg_out = r.new_seg;
   assign new_ptr_out      = r.new_ptr;
   assign vec_out          = r.vec;
   assign intr_taken_out   = r.intr_taken;

   // checks
   logic idle_end;
   assign idle_end = (r.st == CEV_IDLE) && boundary_in;

   property p_push_order;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (r.st == CEV_PSW && bus_done_in) |=> (r.st == CEV_PCS && bus_wdata_out == r.code_seg);
   endproperty
   a_push_order: assert property (p_push_order) else $error("push order wrong");

   property p_push_ret;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (r.st == CEV_PCS && bus_done_in) |=> (r.st == CEV_PIP && bus_wdata_out == r.ret_ptr);
   endproperty
   a_push_ret: assert property (p_push_ret) else $error("return offset push wrong");

   property p_copro_ret;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && !undef_in && opcode_in >= OPC_COPRO_LO && opcode_in <= OPC_COPRO_HI)
         |=> (r.ret_ptr == $past(start_ptr_in) && r.vec == VEC_COPRO);
   endproperty
   a_copro_ret: assert property (p_copro_ret) else $error("coprocessor trap return wrong");

   property p_next_ret;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && dif.exc && !dif.at_start) |=> (r.ret_ptr == $past(next_ptr_in));
   endproperty
   a_next_ret: assert property (p_next_ret) else $error("exception return wrong");

   property p_tbl;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (r.st == CEV_RIP) |-> (bus_op_out == CEV_OP_TABLE && bus_addr_out == {6'h00, r.vec, 2'h0});
   endproperty
   a_tbl: assert property (p_tbl) else $error("table address wrong");

   property p_nmi;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && !dif.exc && r.nmi_pend) |=> (r.st == CEV_PSW && r.vec == VEC_NMI);
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi entry wrong");

   property p_flags;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      flags_wr_out |-> (!flags_out[SW_IE_BIT] && !flags_out[SW_STEP_BIT] && busy_out &&
         (($past(flags_in) ^ flags_out) &
          ~((16'h0001 << SW_IE_BIT) | (16'h0001 << SW_STEP_BIT))) == 16'h0000);
   endproperty
   a_flags: assert property (p_flags) else $error("entry flags not cleared");

   property p_step;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && !dif.exc && !r.nmi_pend && !(intr_req_in && flags_in[SW_IE_BIT]) &&
       flags_in[SW_STEP_BIT] && !dif.no_step) |=> (r.vec == VEC_STEP && flags_wr_out);
   endproperty
   a_step: assert property (p_step) else $error("single step not raised");

   property p_div;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && div_ovf_in && !undef_in &&
       !(opcode_in >= OPC_COPRO_LO && opcode_in <= OPC_COPRO_HI))
         |=> (r.vec == VEC_DIV && busy_out);
   endproperty
   a_div: assert property (p_div) else $error("divide error not raised");

   property p_redirect;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (r.st == CEV_RCS && bus_done_in) |=> (redirect_out && new_code_seg_out == $past(bus_rdata_in))
         ##1 !busy_out;
   endproperty
   a_redirect: assert property (p_redirect) else $error("redirect wrong");

   property p_exc_first;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (idle_end && dif.exc) |=> (r.vec == $past(dif.vec) && !intr_taken_out);
   endproperty
   a_exc_first: assert property (p_exc_first) else $error("exception not first");

   c_ack:   cover property (@(posedge clk_sys_in) r.st == CEV_ACK && bus_done_in);
   c_nmi:   cover property (@(posedge clk_sys_in) idle_end && take_nmi);
   c_copro: cover property (@(posedge clk_sys_in) idle_end && dif.at_start);
   c_step:  cover property (@(posedge clk_sys_in) idle_end && take_step);
endmodule
`default_nettype wire

// [cev_bus_partner.sv]
// bus unit and acknowledge responder standing behind the vectoring unit
// assumes one request at a time, held by the unit until bus_done_out is seen
`timescale 1ns/1ps
`default_nettype none
module cev_bus_partner (
   // clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 nrst_in,
   // request side
   input  wire logic                 bus_req_in,
   input  wire cev_pkg::cev_bus_op_t bus_op_in,
   input  wire logic [15:0]          bus_addr_in,
   input  wire logic [7:0]           ack_vec_in,
   // answer side
   output logic                      bus_done_out,
   output logic [15:0]               bus_rdata_out
);
   import cev_pkg::*;
   logic [1:0] wait_r;
   logic [1:0] dly_r;

   // answer delay cycles 0,1,2 so both prompt and slow replies are seen
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus_done_out  <= 1'b0;
         bus_rdata_out <= 16'h0000;
         wait_r        <= 2'h0;
         dly_r         <= 2'h0;
      end else if (bus_req_in && !bus_done_out && wait_r == dly_r) begin
         bus_done_out <= 1'b1;
         if (bus_op_in == CEV_OP_ACK) begin
            bus_rdata_out <= {~bus_rdata_out[15:8], ack_vec_in};
         end else begin
            bus_rdata_out <= bus_addr_in ^ 16'h5a00;
         end
         wait_r <= 2'h0;
         dly_r  <= (dly_r == 2'h2) ? 2'h0 : dly_r + 2'h1;
      end else begin
         // data is only valid with done, so it toggles in between
         bus_done_out  <= 1'b0;
         bus_rdata_out <= ~bus_rdata_out;
         if (bus_req_in && !bus_done_out) begin
            wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [cpu_exception_vectoring_bench.sv]
// self-checking bench of the exception and interrupt entry sequencer
// assumes cev_bus_partner answers the bus; the bench plays pipeline and controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module cpu_exception_vectoring_bench;
   import cev_pkg::*;
   typedef struct {logic [7:0] vec; logic [15:0] flg, seg, ret; bit ack, tk;} cev_exp_t;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, boundary_in = 1'b0, div_ovf_in = 1'b0;
   logic undef_in = 1'b0, nmi_in = 1'b0, intr_req_in = 1'b0, intr_internal_in = 1'b0;
   logic [7:0] opcode_in = 8'h00, imm8_in = 8'h00, intr_vec_in = 8'h00, ack_vec = 8'h00;
   logic [15:0] range_idx_in = 16'h0000, range_lo_in = 16'hfff0, range_hi_in = 16'h0040;
   logic [15:0] flags_in = 16'h0000, code_seg_in = 16'h0000;
   logic [15:0] next_ptr_in = 16'h0000, start_ptr_in = 16'h0000;
   logic intr_taken_out, bus_req_out, bus_done_in, busy_out, flags_wr_out, redirect_out;
   cev_bus_op_t bus_op_out;
   logic [15:0] bus_addr_out, bus_wdata_out, bus_rdata_in, flags_out, new_code_seg_out;
   logic [15:0] new_ptr_out;
   logic [7:0]  vec_out;
   int          n_errors = 0, n_tests = 0, seed, i;
   cev_exp_t    expq[$];
   logic [15:0] pushes[$];
   bit          ack_seen = 0, taken_seen = 0;
   logic [7:0]  v;

   always #10 clk_sys_in = ~clk_sys_in;

   cev_vector_unit #(.TBL_ENTRIES(256)) DUT (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .boundary_in(boundary_in),
      .opcode_in(opcode_in), .imm8_in(imm8_in), .div_ovf_in(div_ovf_in),
      .undef_in(undef_in), .range_idx_in(range_idx_in), .range_lo_in(range_lo_in),
      .range_hi_in(range_hi_in), .flags_in(flags_in), .code_seg_in(code_seg_in),
      .next_ptr_in(next_ptr_in), .start_ptr_in(start_ptr_in), .nmi_in(nmi_in),
      .intr_req_in(intr_req_in), .intr_internal_in(intr_internal_in),
      .intr_vec_in(intr_vec_in), .intr_taken_out(intr_taken_out),
      .bus_req_out(bus_req_out), .bus_op_out(bus_op_out), .bus_addr_out(bus_addr_out),
      .bus_wdata_out(bus_wdata_out), .bus_done_in(bus_done_in),
      .bus_rdata_in(bus_rdata_in), .busy_out(busy_out), .flags_wr_out(flags_wr_out),
      .flags_out(flags_out), .redirect_out(redirect_out),
      .new_code_seg_out(new_code_seg_out), .new_ptr_out(new_ptr_out), .vec_out(vec_out));

   cev_bus_partner partner (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bus_req_in(bus_req_out),
      .bus_op_in(bus_op_out), .bus_addr_in(bus_addr_out), .ack_vec_in(ack_vec),
      .bus_done_out(bus_done_in), .bus_rdata_out(bus_rdata_in));

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic logic [15:0] fl(input bit st, input bit ie, input bit ov);
      logic [15:0] r;
      r = 16'($random(seed));
      r[SW_STEP_BIT] = st;
      r[SW_IE_BIT] = ie;
      r[SW_OVF_BIT] = ov;
      return r;
   endfunction

   // one finished instruction; ev < 0 means nothing may be served
   task automatic entry(input logic [7:0] op, input logic [7:0] im, input logic [15:0] flg,
                        input logic [2:0] misc, input int ev, input bit sp, input bit ac,
                        input bit tk);
      cev_exp_t    e;
      int          k;
      logic [15:0] sg, np;
      sg = 16'($random(seed));
      np = 16'($random(seed));
      @(posedge clk_sys_in);
      opcode_in <= op;
      imm8_in <= im;
      flags_in <= flg;
      div_ovf_in <= misc[0];
      undef_in <= misc[1];
      range_idx_in <= misc[2] ? 16'hffe0 : 16'h0040;
      code_seg_in <= sg;
      next_ptr_in <= np;
      start_ptr_in <= np - 16'h0003;
      boundary_in <= 1'b1;
      if (ev >= 0) begin
         e.vec = ev[7:0];
         e.flg = flg;
         e.seg = sg;
         e.ret = sp ? np - 16'h0003 : np;
         e.ack = ac;
         e.tk = tk;
         expq.push_back(e);
      end
      @(posedge clk_sys_in);
      boundary_in <= 1'b0;
      k = 0;
      if (ev < 0) begin
         repeat (3) @(negedge clk_sys_in);
         `CHK(busy_out, 1'b0)
      end else begin
         @(negedge clk_sys_in);
         while (busy_out !== 1'b0 && k < 300) begin
            @(negedge clk_sys_in);
            k++;
         end
      end
      if (k >= 300) begin
         n_errors++;
         $display("unexpected at %0t: entry never finished", $time);
         conclude();
      end
   endtask

   // watches the unit's outputs and checks each finished entry
   always @(negedge clk_sys_in) begin : watch
      cev_exp_t    e;
      logic [15:0] f;
      if (bus_req_out && bus_done_in && bus_op_out === CEV_OP_PUSH) begin
         pushes.push_back(bus_wdata_out);
      end
      if (bus_req_out && bus_op_out === CEV_OP_ACK) begin
         ack_seen = 1;
      end
      if (intr_taken_out === 1'b1) begin
         taken_seen = 1;
      end
      if (flags_wr_out === 1'b1 && expq.size() > 0) begin
         f = expq[0].flg;
         f[SW_STEP_BIT] = 1'b0;
         f[SW_IE_BIT] = 1'b0;
         `CHK(flags_out, f)
      end
      if (redirect_out === 1'b1) begin
         `CHK(expq.size() > 0, 1'b1)
         e = expq.pop_front();
         `CHK(vec_out, e.vec)
         `CHK(new_ptr_out, {6'h00, e.vec, 2'h0} ^ 16'h5a00)
         `CHK(new_code_seg_out, {6'h00, e.vec, 2'h2} ^ 16'h5a00)
         `CHK(pushes.size() == 3, 1'b1)
         `CHK(pushes[0], e.flg)
         `CHK(pushes[1], e.seg)
         `CHK(pushes[2], e.ret)
         `CHK(ack_seen, e.ack)
         `CHK(taken_seen, e.tk)
         pushes.delete();
         ack_seen = 0;
         taken_seen = 0;
      end
   end

   initial begin
      seed = 54684;
      repeat (3) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      entry(OPC_BRK, 8'h00, fl(0, 1, 0), 3'h0, 3, 0, 0, 0);
      for (i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'hff : 8'($random(seed));
         entry(OPC_TRAP_N, v, fl(0, 0, 0), 3'h0, v, 0, 0, 0);
      end
      entry(OPC_OVF_TRAP, 8'h00, fl(0, 0, 1), 3'h0, 4, 0, 0, 0);
      entry(OPC_OVF_TRAP, 8'h00, fl(0, 0, 0), 3'h0, -1, 0, 0, 0);
      entry(OPC_RANGE, 8'h00, fl(0, 0, 0), 3'h4, 5, 0, 0, 0);
      entry(OPC_RANGE, 8'h00, fl(0, 0, 0), 3'h0, -1, 0, 0, 0);
      entry(8'h90, 8'h00, fl(0, 0, 0), 3'h2, 6, 0, 0, 0);
      for (i = 0; i < 8; i++) begin
         entry(OPC_COPRO_LO + 8'(i), 8'h00, fl(0, 1, 0), 3'h0, 7, 1, 0, 0);
      end
      entry(8'hf7, 8'h00, fl(0, 0, 0), 3'h1, 0, 0, 0, 0);
      entry(8'h90, 8'h00, fl(1, 1, 0), 3'h0, 1, 0, 0, 0);
      entry(OPC_WAIT, 8'h00, fl(1, 0, 0), 3'h0, -1, 0, 0, 0);
      entry(8'h26, 8'h00, fl(1, 0, 0), 3'h0, -1, 0, 0, 0);
      entry(8'h90, 8'h00, fl(1, 0, 0), 3'h2, 6, 0, 0, 0);
      @(posedge clk_sys_in);
      nmi_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      nmi_in <= 1'b0;
      entry(8'h90, 8'h00, fl(0, 0, 0), 3'h0, 2, 0, 0, 0);
      @(posedge clk_sys_in);
      v = 8'($random(seed));
      intr_vec_in <= v;
      intr_internal_in <= 1'b1;
      intr_req_in <= 1'b1;
      entry(8'h90, 8'h00, fl(0, 0, 0), 3'h0, -1, 0, 0, 0);
      entry(OPC_BRK, 8'h00, fl(0, 1, 0), 3'h0, 3, 0, 0, 0);
      entry(8'h90, 8'h00, fl(0, 1, 0), 3'h0, v, 0, 0, 1);
      @(posedge clk_sys_in);
      v = 8'($random(seed));
      ack_vec <= v;
      intr_internal_in <= 1'b0;
      entry(8'h90, 8'h00, fl(1, 1, 0), 3'h0, v, 0, 1, 1);
      @(posedge clk_sys_in);
      intr_req_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      `CHK(expq.size() == 0, 1'b1)
      conclude();
   end
endmodule
`default_nettype wire
